// ### logic/hppc_top.sv
// Purpose: Pin control of the parallel host port of the device.
// Assumes: All inputs synchronous to i_clock; i_reset is the device reset.
// Notes: Three-state pins are split into value and output enable.
`timescale 1ns/100ps
module hppc_top
  import hppc_pkg::*;
#(
  parameter int TURN_COUNT = TURN_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_output_enable_n_off,
  input wire logic i_host_port_select_strap,
  input wire logic i_wide_host_mode_strap,
  input wire logic i_host_read_not_write,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_data_strobe_1,
  input wire logic i_host_data_strobe_2,
  input wire logic i_host_register_select_0,
  input wire logic i_host_register_select_1,
  input wire logic i_core_ready,
  input wire logic i_core_interrupt,
  output logic o_host_ready_out,
  output logic o_host_ready_out_oe,
  output logic o_host_interrupt_out_n,
  output logic o_host_interrupt_out_n_oe,
  output logic o_host_port_selected,
  output logic o_wide_host_mode,
  output logic o_input_pullups_on,
  output logic o_data_holders_on,
  output logic o_access_strobe,
  output logic o_access_read,
  output logic [1:0] o_access_register
);

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Reset is async; straps are taken by a clocked process on the first
  // edge after release, never loaded from a port under reset.
  logic straps_taken;
  logic port_selected;
  logic wide_mode;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      straps_taken <= 1'b0;
    else
      straps_taken <= 1'b1;
  end

  // Later strap changes are ignored until the next reset
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      port_selected <= RESET_SELECT;
    else if (!straps_taken)
      port_selected <= i_host_port_select_strap;
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      wide_mode <= RESET_WIDE;
    else if (!straps_taken)
      wide_mode <= i_wide_host_mode_strap;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  function automatic logic strobe_active(input logic s1, input logic s2);
    strobe_active = !(s1 & s2);
  endfunction

  logic access_on;
  logic access_start;
  assign access_on = port_selected && straps_taken && !i_host_chip_select_n
                     && strobe_active(i_host_data_strobe_1, i_host_data_strobe_2);

  hppc_state_t state;
  hppc_state_t next_state;
  logic [TURN_W-1:0] turn_count;

  assign access_start = (state == HPPC_IDLE) && access_on;

  always_comb
  begin
    next_state = state;
    case (state)
      HPPC_IDLE:
      begin
        if (access_on)
          next_state = HPPC_BUSY;
      end
      HPPC_BUSY:
      begin
        if (turn_count == TURN_W'(1) && i_core_ready)
          next_state = HPPC_DONE;
      end
      HPPC_DONE:
      begin
        // Host must release before the next access is taken
        if (!access_on)
          next_state = HPPC_IDLE;
      end
      default: next_state = HPPC_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      state <= HPPC_IDLE;
    else
      state <= next_state;
  end

  // Minimum busy time lets the core see the request before ready returns
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      turn_count <= '0;
    else if (access_start)
      turn_count <= TURN_W'(TURN_COUNT);
    else if (state == HPPC_BUSY && turn_count > TURN_W'(1))
      turn_count <= turn_count - TURN_W'(1);
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_access_strobe <= 1'b0;
    else
      o_access_strobe <= access_start;
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_access_read <= 1'b0;
    else if (access_start)
      o_access_read <= i_host_read_not_write;
  end

  // Register select ignored in wide mode
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_access_register <= 2'h0;
    else if (access_start)
      o_access_register <= wide_mode ? 2'h0
        : {i_host_register_select_1, i_host_register_select_0};
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  // Ready follows the next state, so the host never sees ready
  // for a transfer that has already been taken.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_host_ready_out <= 1'b0;
    else
      o_host_ready_out <= (next_state == HPPC_IDLE) && i_core_ready;
  end

  // A deselected port floats ready just as the off input does
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_host_ready_out_oe <= 1'b0;
    else
      o_host_ready_out_oe <= i_output_enable_n_off && port_selected;
  end

  // Reset drives the pin high even with the off input low; the off
  // input takes over from the first edge after release.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_host_interrupt_out_n <= INT_IDLE_LEVEL;
    else
      o_host_interrupt_out_n <= !(i_core_interrupt && !wide_mode);
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_host_interrupt_out_n_oe <= 1'b1;
    else
      o_host_interrupt_out_n_oe <= i_output_enable_n_off && !wide_mode;
  end

  // ----------------------------------------
  // Strap and keeper outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_host_port_selected <= 1'b0;
      o_wide_host_mode <= 1'b0;
    end
    else
    begin
      o_host_port_selected <= port_selected;
      o_wide_host_mode <= wide_mode;
    end
  end

  // Keepers stay on under reset, while no selection is known yet
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_input_pullups_on <= 1'b1;
      o_data_holders_on <= 1'b1;
    end
    else
    begin
      o_input_pullups_on <= !port_selected;
      o_data_holders_on <= !port_selected;
    end
  end

endmodule

// ### logic/hppc_pkg.sv
// Purpose: Constants for the host port pin control block.
// Assumes: One 40 MHz clock, inputs synchronous to it.
// Notes: Pin-level strap capture, ready and interrupt output control.
// Summary of operation
// - Ready asserted only when port accepts transfer
// - Output disable low floats ready output
// - Interrupt output driven high during reset
// - Output disable low floats interrupt output
// - Wide mode leaves interrupt output unused
// - Deselected port enables pullups and bus holders
// - Select strap captured at reset release only
// - Wide mode only when wide strap high
package hppc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_MHZ = 40;
  localparam int TURN_NS = 50;
  localparam int TURN_CYCLES = (TURN_NS * CLOCK_MHZ + 999) / 1000;
  localparam int TURN_W = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RESET_SELECT = 1'b0;
  localparam logic RESET_WIDE = 1'b0;
  localparam logic INT_IDLE_LEVEL = 1'b1;

  // ----------------------------------------
  // Access sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    HPPC_IDLE = 3'b001,
    HPPC_BUSY = 3'b010,
    HPPC_DONE = 3'b100
  } hppc_state_t;

endpackage

// ### bench/hppc_top_asserts.sv
// Purpose: pin control checker
// Assumes: bound to hppc_top
// Notes: straps show on the ports two edges after release
`timescale 1ns/100ps
module hppc_top_asserts (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_output_enable_n_off,
  input wire logic i_host_port_select_strap,
  input wire logic i_wide_host_mode_strap,
  input wire logic o_host_ready_out,
  input wire logic o_host_ready_out_oe,
  input wire logic o_host_interrupt_out_n,
  input wire logic o_host_interrupt_out_n_oe,
  input wire logic o_host_port_selected,
  input wire logic o_wide_host_mode,
  input wire logic o_input_pullups_on,
  input wire logic o_data_holders_on,
  input wire logic o_access_strobe
);
  default clocking @(posedge i_clock);
  endclocking
  sequence s_rel; $fell(i_reset); endsequence
  // Straps land inside one edge after release, on the ports one later
  property p_cap; disable iff (i_reset) s_rel |-> ##2 (o_host_port_selected ==
    $past(i_host_port_select_strap, 2) && o_wide_host_mode == $past(i_wide_host_mode_strap, 2));
  endproperty
  a_cap: assert property (p_cap) else $error("cap");
  property p_hold; disable iff (i_reset) !$past(i_reset, 3) && !$past(i_reset, 2) |->
    $stable(o_host_port_selected) && $stable(o_wide_host_mode); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  // Checked inside reset on purpose
  property p_irst; i_reset |-> o_host_interrupt_out_n; endproperty
  a_irst: assert property (p_irst) else $error("irst");
  property p_rdy; disable iff (i_reset) o_access_strobe |-> !o_host_ready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  property p_roff; disable iff (i_reset) !i_output_enable_n_off |=> !o_host_ready_out_oe;
  endproperty
  a_roff: assert property (p_roff) else $error("roff");
  property p_ioff; disable iff (i_reset)
    !i_output_enable_n_off |=> !o_host_interrupt_out_n_oe; endproperty
  a_ioff: assert property (p_ioff) else $error("ioff");
  property p_wide; disable iff (i_reset) o_wide_host_mode |=> !o_host_interrupt_out_n_oe;
  endproperty
  a_wide: assert property (p_wide) else $error("wide");
  property p_sel; disable iff (i_reset)
    !o_host_port_selected |-> o_input_pullups_on && o_data_holders_on; endproperty
  a_sel: assert property (p_sel) else $error("sel");
endmodule
bind hppc_top hppc_top_asserts u_chk (.*);

// ### bench/hppc_host.sv
// Purpose: host model
// Assumes: idle pins pulled high
// Notes: waits a bounded time for ready
`timescale 1ns/100ps
module hppc_host (
  input wire logic i_clock,
  input wire logic i_ready,
  output logic o_rnw,
  output logic o_cs_n,
  output logic o_ds1,
  output logic o_ds2,
  output logic o_rs0,
  output logic o_rs1
);
  initial {o_rnw, o_cs_n, o_ds1, o_ds2, o_rs0, o_rs1} = 6'h3F;
  task automatic go(input logic rnw, input logic [1:0] rs, output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 20 && !ok; k++)
    begin
      @(posedge i_clock);
      ok = (i_ready === 1'b1);
    end
    o_rnw <= rnw;
    {o_rs1, o_rs0} <= rs;
    o_cs_n <= 1'b0;
    o_ds1 <= ~rnw;
    o_ds2 <= rnw;
    repeat (3) @(posedge i_clock);
    {o_rnw, o_cs_n, o_ds1, o_ds2, o_rs0, o_rs1} <= 6'h3F;
  endtask
endmodule

// ### bench/test_host_port_pin_control.sv
// Purpose: pin control bench
// Assumes: host model drives access pins
// Notes: straps move around reset and once after it, where they must be ignored
`timescale 1ns/100ps
module test_host_port_pin_control;
  logic i_clock = 0, i_reset = 0, i_output_enable_n_off = 1, i_host_port_select_strap = 1;
  logic i_wide_host_mode_strap = 0, i_core_ready = 1, i_core_interrupt = 1, ok, rd;
  logic i_host_read_not_write, i_host_chip_select_n, i_host_data_strobe_1;
  logic i_host_data_strobe_2, i_host_register_select_0, i_host_register_select_1;
  logic o_host_ready_out, o_host_ready_out_oe, o_host_interrupt_out_n, o_access_strobe;
  logic o_host_interrupt_out_n_oe, o_host_port_selected, o_wide_host_mode, o_access_read;
  logic o_input_pullups_on, o_data_holders_on;
  logic [1:0] o_access_register, rg;
  int failures = 0, n_tests = 0, n_str = 0;
  hppc_top u_dut (.*);
  hppc_host u_host (
    .i_clock(i_clock),
    .i_ready(o_host_ready_out_oe ? o_host_ready_out : 1'bz),
    .o_rnw(i_host_read_not_write),
    .o_cs_n(i_host_chip_select_n),
    .o_ds1(i_host_data_strobe_1),
    .o_ds2(i_host_data_strobe_2),
    .o_rs0(i_host_register_select_0),
    .o_rs1(i_host_register_select_1)
  );
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock)
    if (o_access_strobe === 1'b1)
    begin
      n_str++;
      {rd, rg} = {o_access_read, o_access_register};
    end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: %h %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset(input logic sel, input logic wide);
    i_reset <= 1'b1;
    i_host_port_select_strap <= sel;
    i_wide_host_mode_strap <= wide;
    repeat (16) @(posedge i_clock);
    chk(o_host_interrupt_out_n, 4'h1);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk({o_host_port_selected, o_wide_host_mode}, {sel, wide});
    chk({o_input_pullups_on, o_data_holders_on}, {2{~sel}});
  endtask
  task automatic t_access();
    do_reset(1'b1, 1'b0);
    chk(o_host_interrupt_out_n, 4'h0);
    i_host_port_select_strap <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      u_host.go(k[0], 2'(k), ok);
      chk({ok, rd, rg}, {1'b1, k[0], 2'(k)});
    end
    chk(4'(n_str), 4'h3);
  endtask
  task automatic t_off();
    i_output_enable_n_off <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk({o_host_ready_out_oe, o_host_interrupt_out_n_oe}, 4'h0);
    i_output_enable_n_off <= 1'b1;
  endtask
  task automatic t_wide();
    do_reset(1'b0, 1'b1);
    chk(o_host_interrupt_out_n_oe, 4'h0);
    u_host.go(1'b1, 2'h3, ok);
    repeat (4) @(posedge i_clock);
    chk({ok, 3'(n_str)}, 4'h3);
  endtask
  task automatic t_wide_sel();
    do_reset(1'b1, 1'b1);
    chk(o_host_interrupt_out_n, 4'h1);
    u_host.go(1'b0, 2'h2, ok);
    chk({ok, rd, rg}, {1'b1, 1'b0, 2'h0});
  endtask
  initial
  begin
    t_access();
    t_off();
    t_wide();
    t_wide_sel();
    print_verdict();
  end
endmodule
